// ---- hdl/hwpk_top.sv ----
// Purpose: Host write port receiver, write recovery and pixel packer
// Assumes: Pins are asynchronous; colour mode and window come from
//          logic on CLK_SYS
// Notes:   Serial link or 8-bit parallel strobe, chosen by a pin
`timescale 1ns/1ns
module hwpk_top
    import hwpk_pkg::*;
#(
    parameter logic [7:0] STORE_CMD = STORE_CMD_DEFAULT
)
(
    input  wire logic                      CLK_SYS,
    input  wire logic                      RESET,
    input  wire logic                      EXTERNAL_CLEAR_N,
    input  wire logic                      PARALLEL_MODE,
    input  wire logic                      SERIAL_SELECT_N,
    input  wire logic                      SERIAL_CLK,
    input  wire logic                      SERIAL_DATA,
    input  wire logic                      DATA_CMD,
    input  wire logic                      PAR_SELECT_N,
    input  wire logic                      PAR_WRITE_N,
    input  wire logic [7:0]                PAR_DATA,
    input  wire logic [1:0]                COLOUR_MODE,
    input  wire logic [ADDR_BITS-1:0]      WIN_FIRST,
    input  wire logic [ADDR_BITS-1:0]      WIN_LAST,
    output logic                           CMD_VALID,
    output logic [7:0]                     CMD_CODE,
    output logic                           PARAM_VALID,
    output logic [7:0]                     PARAM_DATA,
    output logic [PARAM_IDX_BITS-1:0]      PARAM_INDEX,
    output logic                           PIX_VALID,
    input  wire logic                      PIX_READY,
    output logic [PIXEL_BITS-1:0]          PIX_DATA,
    output logic [ADDR_BITS-1:0]           PIX_ADDR,
    output logic                           OVERRUN
);
    // ------------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------------
    logic [SY_WIDTH-1:0] meta_reg;
    logic [SY_WIDTH-1:0] sync_reg;
    logic                sclk_prev_reg;
    logic                wr_prev_reg;

    always_ff @(posedge CLK_SYS)
    begin
        if (RESET)
        begin
            meta_reg      <= SY_RESET;
            sync_reg      <= SY_RESET;
            sclk_prev_reg <= 1'b0;
            wr_prev_reg   <= 1'b1;
        end
        else
        begin
            meta_reg      <= {PAR_DATA, PARALLEL_MODE, PAR_WRITE_N,
                              PAR_SELECT_N, EXTERNAL_CLEAR_N, DATA_CMD,
                              SERIAL_DATA, SERIAL_SELECT_N, SERIAL_CLK};
            sync_reg      <= meta_reg;
            sclk_prev_reg <= sync_reg[SY_SCLK];
            wr_prev_reg   <= sync_reg[SY_WR_N];
        end
    end

    logic       clear_low;
    logic       par_mode;
    logic       sel_idle;
    logic       sclk_rise;
    logic       wr_rise;
    logic [7:0] pdata;

    assign clear_low = ~sync_reg[SY_CLEAR_N];
    assign par_mode  = sync_reg[SY_PAR_MODE];
    assign sel_idle  = sync_reg[SY_SEL_N];
    assign sclk_rise = sync_reg[SY_SCLK] & ~sclk_prev_reg;
    assign wr_rise   = sync_reg[SY_WR_N] & ~wr_prev_reg;
    assign pdata     = sync_reg[SY_PDATA +: BYTE_BITS];

    // ------------------------------------------------------------------
    // Byte receiver
    // ------------------------------------------------------------------
    logic [2:0] bit_cnt_reg,   bit_cnt_next;
    logic [6:0] shift_reg,     shift_next;
    logic       byte_vld_reg,  byte_vld_next;
    logic [7:0] byte_reg,      byte_next;
    logic       byte_dc_reg,   byte_dc_next;
    logic       overrun_reg,   overrun_next;
    logic       consume;
    logic       got_byte;

    always_comb
    begin
        bit_cnt_next = bit_cnt_reg;
        shift_next   = shift_reg;
        byte_next    = byte_reg;
        byte_dc_next = byte_dc_reg;
        got_byte     = 1'b0;
        if (clear_low || par_mode || sel_idle)
        begin
            bit_cnt_next = '0;
        end
        else if (sclk_rise)
        begin
            if (bit_cnt_reg == LAST_BIT)
            begin
                byte_next    = {shift_reg, sync_reg[SY_SDA]};
                byte_dc_next = sync_reg[SY_DC];
                got_byte     = 1'b1;
                bit_cnt_next = '0;
            end
            else
            begin
                shift_next   = {shift_reg[5:0], sync_reg[SY_SDA]};
                bit_cnt_next = bit_cnt_reg + 3'h1;
            end
        end
        if (!clear_low && par_mode && !sync_reg[SY_PSEL_N] && wr_rise)
        begin
            byte_next    = pdata;
            byte_dc_next = sync_reg[SY_DC];
            got_byte     = 1'b1;
        end
        byte_vld_next = got_byte | (byte_vld_reg & ~consume);
        overrun_next  = overrun_reg | (got_byte & byte_vld_reg & ~consume);
    end

    always_ff @(posedge CLK_SYS)
    begin
        if (RESET)
        begin
            bit_cnt_reg  <= '0;
            shift_reg    <= '0;
            byte_vld_reg <= 1'b0;
            byte_reg     <= '0;
            byte_dc_reg  <= 1'b0;
            overrun_reg  <= 1'b0;
        end
        else
        begin
            bit_cnt_reg  <= bit_cnt_next;
            shift_reg    <= shift_next;
            byte_vld_reg <= byte_vld_next;
            byte_reg     <= byte_next;
            byte_dc_reg  <= byte_dc_next;
            overrun_reg  <= overrun_next;
        end
    end

    // ------------------------------------------------------------------
    // Command decode and pixel packer
    // ------------------------------------------------------------------
    function automatic logic [5:0] wide4(input logic [3:0] n);
        wide4 = {n, n[3:2]};
    endfunction : wide4

    function automatic logic [5:0] wide5(input logic [4:0] f);
        wide5 = {f, f[4]};
    endfunction : wide5

    logic                      store_on_reg, store_on_next;
    logic                      await_reg,    await_next;
    logic [1:0]                pack_reg,     pack_next;
    logic [7:0]                hold0_reg,    hold0_next;
    logic [7:0]                hold1_reg,    hold1_next;
    logic                      pend_reg,     pend_next;
    logic [PIXEL_BITS-1:0]     word_reg,     word_next;
    logic [ADDR_BITS-1:0]      waddr_reg,    waddr_next;
    logic [ADDR_BITS-1:0]      addr_reg,     addr_next;
    logic                      cmd_v_reg,    cmd_v_next;
    logic [7:0]                cmd_reg,      cmd_next;
    logic                      par_v_reg,    par_v_next;
    logic [7:0]                par_reg,      par_next;
    logic [PARAM_IDX_BITS-1:0] idx_reg,      idx_next;
    logic [PARAM_IDX_BITS-1:0] idx_out_reg,  idx_out_next;
    logic                      buf_ready;
    logic                      done;
    logic [PIXEL_BITS-1:0]     pix;
    hwpk_depth_e               depth;

    assign depth   = hwpk_depth_e'(COLOUR_MODE);
    assign consume = byte_vld_reg & ~pend_reg;

    always_comb
    begin
        store_on_next = store_on_reg;
        await_next    = await_reg;
        pack_next     = pack_reg;
        hold0_next    = hold0_reg;
        hold1_next    = hold1_reg;
        pend_next     = pend_reg & ~buf_ready;
        word_next     = word_reg;
        waddr_next    = waddr_reg;
        addr_next     = addr_reg;
        cmd_v_next    = 1'b0;
        cmd_next      = cmd_reg;
        par_v_next    = 1'b0;
        par_next      = par_reg;
        idx_next      = idx_reg;
        idx_out_next  = idx_out_reg;
        done          = 1'b0;
        pix           = '0;
        if (clear_low)
        begin
            store_on_next = 1'b0;
            await_next    = 1'b1;
            pack_next     = '0;
        end
        else if (consume && !byte_dc_reg)
        begin
            cmd_v_next    = 1'b1;
            cmd_next      = byte_reg;
            await_next    = 1'b0;
            pack_next     = '0;
            idx_next      = '0;
            store_on_next = (byte_reg == STORE_CMD);
            if (byte_reg == STORE_CMD)
            begin
                addr_next = WIN_FIRST;
            end
        end
        else if (consume && !await_reg && !store_on_reg)
        begin
            par_v_next   = 1'b1;
            par_next     = byte_reg;
            idx_out_next = idx_reg;
            if (idx_reg != '1)
            begin
                idx_next = idx_reg + 1'b1;
            end
        end
        else if (consume && !await_reg)
        begin
            unique case (depth)
                DEPTH8:
                begin
                    done = 1'b1;
                    pix  = {byte_reg[7:5], byte_reg[7:5],
                            byte_reg[4:2], byte_reg[4:2],
                            byte_reg[1:0], byte_reg[1:0], byte_reg[1:0]};
                end
                DEPTH12:
                begin
                    pack_next = (pack_reg == 2'h2) ? 2'h0 : pack_reg + 2'h1;
                    if (pack_reg == 2'h0)
                    begin
                        hold0_next = byte_reg;
                    end
                    else if (pack_reg == 2'h1)
                    begin
                        hold1_next = byte_reg;
                        done = 1'b1;
                        pix  = {wide4(hold0_reg[7:4]), wide4(hold0_reg[3:0]),
                                wide4(byte_reg[7:4])};
                    end
                    else
                    begin
                        done = 1'b1;
                        pix  = {wide4(hold1_reg[3:0]), wide4(byte_reg[7:4]),
                                wide4(byte_reg[3:0])};
                    end
                end
                DEPTH16:
                begin
                    pack_next = (pack_reg == 2'h0) ? 2'h1 : 2'h0;
                    if (pack_reg == 2'h0)
                    begin
                        hold0_next = byte_reg;
                    end
                    else
                    begin
                        done = 1'b1;
                        pix  = {wide5(hold0_reg[7:3]),
                                hold0_reg[2:0], byte_reg[7:5],
                                wide5(byte_reg[4:0])};
                    end
                end
                DEPTH18:
                begin
                    pack_next = (pack_reg == 2'h2) ? 2'h0 : pack_reg + 2'h1;
                    if (pack_reg == 2'h0)
                    begin
                        hold0_next = byte_reg;
                    end
                    else if (pack_reg == 2'h1)
                    begin
                        hold1_next = byte_reg;
                    end
                    else
                    begin
                        done = 1'b1;
                        pix  = {hold0_reg[7:2], hold1_reg[7:2],
                                byte_reg[7:2]};
                    end
                end
            endcase
        end
        if (done)
        begin
            pend_next  = 1'b1;
            word_next  = pix;
            waddr_next = addr_reg;
            addr_next  = (addr_reg == WIN_LAST) ? WIN_FIRST
                                                : addr_reg + 1'b1;
        end
    end

    always_ff @(posedge CLK_SYS)
    begin
        if (RESET)
        begin
            store_on_reg <= 1'b0;
            await_reg    <= 1'b1;
            pack_reg     <= '0;
            hold0_reg    <= '0;
            hold1_reg    <= '0;
            pend_reg     <= 1'b0;
            word_reg     <= '0;
            waddr_reg    <= '0;
            addr_reg     <= '0;
            cmd_v_reg    <= 1'b0;
            cmd_reg      <= '0;
            par_v_reg    <= 1'b0;
            par_reg      <= '0;
            idx_reg      <= '0;
            idx_out_reg  <= '0;
        end
        else
        begin
            store_on_reg <= store_on_next;
            await_reg    <= await_next;
            pack_reg     <= pack_next;
            hold0_reg    <= hold0_next;
            hold1_reg    <= hold1_next;
            pend_reg     <= pend_next;
            word_reg     <= word_next;
            waddr_reg    <= waddr_next;
            addr_reg     <= addr_next;
            cmd_v_reg    <= cmd_v_next;
            cmd_reg      <= cmd_next;
            par_v_reg    <= par_v_next;
            par_reg      <= par_next;
            idx_reg      <= idx_next;
            idx_out_reg  <= idx_out_next;
        end
    end

    // ------------------------------------------------------------------
    // Output buffer and ports
    // ------------------------------------------------------------------
    hwpk_pair_buf #(
        .WIDTH (ADDR_BITS + PIXEL_BITS),
        .DEPTH (BUF_DEPTH)
    ) u_buf (
        .clk       (CLK_SYS),
        .rst       (RESET),
        .in_valid  (pend_reg),
        .in_ready  (buf_ready),
        .in_data   ({waddr_reg, word_reg}),
        .out_valid (PIX_VALID),
        .out_ready (PIX_READY),
        .out_data  ({PIX_ADDR, PIX_DATA})
    );

    assign CMD_VALID   = cmd_v_reg;
    assign CMD_CODE    = cmd_reg;
    assign PARAM_VALID = par_v_reg;
    assign PARAM_DATA  = par_reg;
    assign PARAM_INDEX = idx_out_reg;
    assign OVERRUN     = overrun_reg;

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    default clocking cb @(posedge CLK_SYS); endclocking
    default disable iff (RESET);

    chk_clear_drops: assert property (clear_low |=> bit_cnt_reg == '0
        && await_reg && !store_on_reg)
        else $error("clear did not drop partial byte");
    chk_release_idle: assert property (sel_idle |=> bit_cnt_reg == '0)
        else $error("select release kept partial bits");
    chk_idle_no_byte: assert property (sel_idle && !par_mode
        |=> !got_byte || par_mode)
        else $error("byte taken while select idle");
    chk_cmd_clears_pack: assert property (consume && !byte_dc_reg
        && !clear_low |=> pack_reg == '0 && CMD_VALID)
        else $error("command did not reset packing");
    chk_param_out: assert property (consume && byte_dc_reg && !await_reg
        && !store_on_reg && !clear_low
        |=> PARAM_VALID && PARAM_DATA == $past(byte_reg))
        else $error("parameter not delivered");
    chk_addr_wrap: assert property (done && addr_reg == WIN_LAST
        |=> addr_reg == WIN_FIRST)
        else $error("pointer did not wrap to window start");
    chk_pix8: assert property (done && depth == DEPTH8
        |=> word_reg[17:15] == $past(byte_reg[7:5]) && pend_reg)
        else $error("8-bit pixel layout wrong");
    chk_pix16_lsb: assert property (done && depth == DEPTH16
        |=> word_reg[12] == word_reg[17] && word_reg[0] == word_reg[5])
        else $error("16-bit red or blue widening wrong");
    chk_pix18_third: assert property (done && depth == DEPTH18
        |-> pack_reg == 2'h2)
        else $error("18-bit pixel before third byte");
    chk_pend_holds: assert property (pend_reg && !buf_ready
        |=> pend_reg && $stable(word_reg))
        else $error("stalled pixel lost");
    chk_addr_range: assert property (PIX_VALID |-> PIX_ADDR <= FRAME_LAST)
        else $error("pixel address outside frame");

    cov_pix12: cover property (done && depth == DEPTH12 ##[1:100] done);
    cov_stall: cover property (PIX_VALID && !PIX_READY && !buf_ready);
    cov_param_cut: cover property (PARAM_VALID ##[1:50] CMD_VALID);
    cov_release_mid: cover property (bit_cnt_reg != '0 ##1 sel_idle);

endmodule : hwpk_top

// ---- hdl/hwpk_pkg.sv ----
// Purpose: Shared constants and types of the host write pixel packer
// Assumes: 50 MHz system clock, 8-bit byte link
// Notes:   Pixel word is 18 bits, frame address 16 bits
package hwpk_pkg;

    // ------------------------------------------------------------------
    // Frame memory geometry
    // ------------------------------------------------------------------
    localparam int FRAME_ROWS   = 240;
    localparam int FRAME_COLS   = 176;
    localparam int PIXEL_BITS   = 18;
    localparam int ADDR_BITS    = 16;
    localparam logic [15:0] FRAME_LAST = 16'(FRAME_ROWS * FRAME_COLS - 1);

    // ------------------------------------------------------------------
    // Byte link
    // ------------------------------------------------------------------
    localparam int BYTE_BITS    = 8;
    localparam logic [2:0] LAST_BIT = 3'h7;
    localparam int PARAM_IDX_BITS = 4;
    localparam logic [7:0] STORE_CMD_DEFAULT = 8'h3C;

    // Synchroniser vector layout
    localparam int SY_SCLK      = 0;
    localparam int SY_SEL_N     = 1;
    localparam int SY_SDA       = 2;
    localparam int SY_DC        = 3;
    localparam int SY_CLEAR_N   = 4;
    localparam int SY_PSEL_N    = 5;
    localparam int SY_WR_N      = 6;
    localparam int SY_PAR_MODE  = 7;
    localparam int SY_PDATA     = 8;
    localparam int SY_WIDTH     = 16;
    localparam logic [15:0] SY_RESET = 16'h0072;

    // Two-entry output buffer
    localparam int BUF_DEPTH    = 2;

    typedef enum logic [1:0] {
        DEPTH8,
        DEPTH12,
        DEPTH16,
        DEPTH18
    } hwpk_depth_e;

endpackage : hwpk_pkg

// ---- hdl/hwpk_pair_buf.sv ----
// Purpose: Small valid/ready buffer on the pixel write path
// Assumes: Synchronous active-high reset
// Notes:   Stalling the drain side fills it and drops in_ready
`timescale 1ns/1ns
module hwpk_pair_buf
    import hwpk_pkg::*;
#(
    parameter int WIDTH = 34,
    parameter int DEPTH = BUF_DEPTH
)
(
    input  wire logic             clk,
    input  wire logic             rst,
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic      [WIDTH-1:0] out_data
);
    localparam int PW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem_reg [DEPTH];
    logic [PW-1:0]    wr_reg;
    logic [PW-1:0]    wr_next;
    logic [PW-1:0]    rd_reg;
    logic [PW-1:0]    rd_next;
    logic [PW:0]      cnt_reg;
    logic [PW:0]      cnt_next;
    logic             push;
    logic             pop;

    function automatic logic [PW-1:0] bump(input logic [PW-1:0] p);
        bump = (p == PW'(DEPTH - 1)) ? '0 : p + 1'b1;
    endfunction : bump

    assign in_ready  = (cnt_reg != (PW+1)'(DEPTH));
    assign out_valid = (cnt_reg != '0);
    assign out_data  = mem_reg[rd_reg];
    assign push      = in_valid & in_ready;
    assign pop       = out_valid & out_ready;

    always_comb
    begin
        wr_next  = push ? bump(wr_reg) : wr_reg;
        rd_next  = pop ? bump(rd_reg) : rd_reg;
        cnt_next = cnt_reg + (PW+1)'(push) - (PW+1)'(pop);
    end

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            wr_reg  <= '0;
            rd_reg  <= '0;
            cnt_reg <= '0;
        end
        else
        begin
            wr_reg  <= wr_next;
            rd_reg  <= rd_next;
            cnt_reg <= cnt_next;
        end
    end

    always_ff @(posedge clk)
    begin
        if (push)
        begin
            mem_reg[wr_reg] <= in_data;
        end
    end

endmodule : hwpk_pair_buf

// ---- verif/hwpk_host.sv ----
// Purpose: Host model that writes bytes over serial or parallel pins
// Assumes: Pins change only at CLK_SYS rising edges
// Notes:   Link clock stands low outside bytes
`timescale 1ns/1ns
module hwpk_host
(
    input  wire logic       clk,
    output logic            sel_n,
    output logic            sclk,
    output logic            sda,
    output logic            dc,
    output logic            psel_n,
    output logic            wr_n,
    output logic      [7:0] pd
);
    initial
    begin
        {sel_n, psel_n, wr_n} = 3'h7;
        {sclk, sda, dc} = 3'h0;
        pd = 8'h00;
    end

    // Sends n leading bits of b serially, or all of b in parallel; fewer than 8 breaks a serial byte off
    task automatic put(input logic par, input logic c,
                       input logic [7:0] b, input int n);
        @(posedge clk);
        dc <= c;
        if (par)
        begin
            psel_n <= 1'b0;
            pd     <= b;
            wr_n   <= 1'b0;
            repeat (4) @(posedge clk);
            wr_n <= 1'b1;
            repeat (4) @(posedge clk);
            psel_n <= 1'b1;
            pd     <= ~b;
        end
        else
        begin
            sel_n <= 1'b0;
            for (int i = 0; i < n; i++)
            begin
                sda <= b[7-i];
                repeat (4) @(posedge clk);
                sclk <= 1'b1;
                repeat (4) @(posedge clk);
                sclk <= 1'b0;
            end
            repeat (4) @(posedge clk);
            sel_n <= 1'b1;
            sda   <= ~sda;
        end
        repeat (4) @(posedge clk);
    endtask : put
endmodule : hwpk_host

// ---- verif/testbench.sv ----
// Purpose: Self-checking bench of the host write pixel packer
// Assumes: Host model drives the pins, bench sinks pixels
// Notes:   Each scenario clears the capture queues first
`timescale 1ns/1ns
module testbench
    import hwpk_pkg::*;
;
    logic        clk, rst, clr_n, pm, sel_n, sclk, sda, dc, psel_n;
    logic        wr_n, cv, pv, xv, xr, ovr;
    logic [7:0]  pd, cc, pdat;
    logic [3:0]  pidx;
    logic [1:0]  cm;
    logic [15:0] wf, wl, xa;
    logic [17:0] xd;
    logic [33:0] pq[$];
    logic [11:0] aq[$];
    logic [7:0]  cq[$];
    int          n_errors = 0;
    int          checked = 0;

    hwpk_host host_u (.clk(clk), .sel_n(sel_n), .sclk(sclk), .sda(sda),
        .dc(dc), .psel_n(psel_n), .wr_n(wr_n), .pd(pd));
    hwpk_top dut_u (.CLK_SYS(clk), .RESET(rst), .EXTERNAL_CLEAR_N(clr_n),
        .PARALLEL_MODE(pm), .SERIAL_SELECT_N(sel_n), .SERIAL_CLK(sclk),
        .SERIAL_DATA(sda), .DATA_CMD(dc), .PAR_SELECT_N(psel_n),
        .PAR_WRITE_N(wr_n), .PAR_DATA(pd), .COLOUR_MODE(cm),
        .WIN_FIRST(wf), .WIN_LAST(wl), .CMD_VALID(cv), .CMD_CODE(cc),
        .PARAM_VALID(pv), .PARAM_DATA(pdat), .PARAM_INDEX(pidx),
        .PIX_VALID(xv), .PIX_READY(xr), .PIX_DATA(xd), .PIX_ADDR(xa),
        .OVERRUN(ovr));

    always @(posedge clk)
    begin
        if (xv === 1'b1 && xr === 1'b1) pq.push_back({xa, xd});
        if (pv === 1'b1) aq.push_back({pidx, pdat});
        if (cv === 1'b1) cq.push_back(cc);
    end

    function automatic logic [17:0] p12(input logic [11:0] v);
        return {v[11:8], v[11:10], v[7:4], v[7:6], v[3:0], v[3:2]};
    endfunction : p12

    task automatic chk(input logic [33:0] g, input logic [33:0] e);
        checked++;
        if (g !== e)
        begin
            n_errors++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask : chk

    task automatic print_verdict();
        $display("checked %0d n_errors %0d", checked, n_errors);
        if (n_errors == 0 && checked > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : print_verdict

    task automatic need(input int np, input int na);
        int k;
        for (k = 0; k < 300; k++)
        begin
            if (pq.size() >= np && aq.size() >= na) break;
            @(posedge clk);
        end
        if (k == 300)
        begin
            n_errors++;
            print_verdict();
        end
        else
        begin
            repeat (20) @(posedge clk);
        end
    endtask : need

    task automatic go(input hwpk_depth_e d, input logic p);
        @(posedge clk);
        cm <= d;
        pm <= p;
        pq.delete();
        aq.delete();
        cq.delete();
        repeat (4) @(posedge clk);
    endtask : go

    task automatic tx(input logic c, input logic [7:0] b);
        host_u.put(pm, c, b, 8);
    endtask : tx

    // ------------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------------
    task automatic t_depth8();
        go(DEPTH8, 1'b0);
        wf <= 16'h0005;
        wl <= 16'h0006;
        xr <= 1'b0;
        tx(1'b0, STORE_CMD_DEFAULT);
        tx(1'b1, 8'hE4);
        tx(1'b1, 8'h1B);
        tx(1'b1, 8'hE4);
        chk(34'(pq.size()), 34'h0);
        xr <= 1'b1;
        need(3, 0);
        chk(pq[0], {16'h0005, 6'h3F, 6'h09, 6'h00});
        chk(pq[1], {16'h0006, 6'h00, 6'h36, 6'h3F});
        chk(pq[2], {16'h0005, 6'h3F, 6'h09, 6'h00});
        chk({33'h0, ovr}, 34'h0);
        $display("depth8 done");
    endtask : t_depth8

    task automatic t_depth12();
        go(DEPTH12, 1'b0);
        wf <= 16'h0000;
        wl <= 16'h0064;
        tx(1'b0, STORE_CMD_DEFAULT);
        tx(1'b1, 8'hA5);
        tx(1'b1, 8'hC3);
        tx(1'b1, 8'h96);
        tx(1'b1, 8'h77);
        tx(1'b0, 8'h00);
        tx(1'b0, STORE_CMD_DEFAULT);
        tx(1'b1, 8'h12);
        tx(1'b1, 8'h34);
        need(3, 0);
        chk(34'(pq.size()), 34'h3);
        chk(pq[0], {16'h0000, p12(12'hA5C)});
        chk(pq[1], {16'h0001, p12(12'h396)});
        chk(pq[2], {16'h0000, p12(12'h123)});
        $display("depth12 done");
    endtask : t_depth12

    task automatic t_depth16();
        go(DEPTH16, 1'b1);
        tx(1'b0, STORE_CMD_DEFAULT);
        tx(1'b1, 8'hA5);
        tx(1'b1, 8'hC3);
        need(1, 0);
        chk(pq[0], {16'h0000, 6'h29, 6'h2E, 6'h06});
        $display("depth16 done");
    endtask : t_depth16

    task automatic t_depth18();
        go(DEPTH18, 1'b0);
        tx(1'b0, STORE_CMD_DEFAULT);
        tx(1'b1, 8'hFC);
        tx(1'b1, 8'h83);
        chk(34'(pq.size()), 34'h0);
        tx(1'b1, 8'h57);
        need(1, 0);
        chk(pq[0], {16'h0000, 6'h3F, 6'h20, 6'h15});
        $display("depth18 done");
    endtask : t_depth18

    task automatic t_recover();
        go(DEPTH8, 1'b0);
        tx(1'b0, 8'h2A);
        tx(1'b1, 8'h11);
        host_u.put(1'b0, 1'b1, 8'h22, 5);
        tx(1'b1, 8'h22);
        host_u.put(1'b0, 1'b1, 8'h33, 3);
        tx(1'b0, 8'h2B);
        tx(1'b1, 8'h44);
        fork
            tx(1'b1, 8'h55);
            begin
                repeat (30) @(posedge clk);
                clr_n <= 1'b0;
                repeat (6) @(posedge clk);
                clr_n <= 1'b1;
            end
        join
        tx(1'b1, 8'h66);
        tx(1'b0, 8'h2D);
        tx(1'b1, 8'h77);
        need(0, 4);
        chk(34'(aq.size()), 34'h4);
        chk(34'(aq[1]), 34'h122);
        chk(34'(aq[2]), 34'h044);
        chk(34'(aq[3]), 34'h077);
        chk(34'(cq.size()), 34'h3);
        chk(34'(cq[2]), 34'h2D);
        $display("recover done");
    endtask : t_recover

    initial
    begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    initial
    begin
        rst = 1'b1;
        clr_n = 1'b1;
        pm = 1'b0;
        xr = 1'b1;
        cm = 2'h0;
        wf = 16'h0000;
        wl = 16'h0064;
        repeat (12) @(posedge clk);
        rst <= 1'b0;
        repeat (3) @(posedge clk);
        t_depth8();
        t_depth12();
        t_depth16();
        t_depth18();
        t_recover();
        print_verdict();
    end
endmodule : testbench
